// ---- hw/ddr4_cmd_addr_pin_decode.sv ----
// command and address pin decoder of the memory device
`timescale 1ns/1ns
`default_nettype none
module ddr4_cmd_addr_pin_decode #(
	parameter int DATA_W = 8,
	parameter bit BYTE_WIDE = 1'b1
) (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic cke_in,
	input wire logic cs_b_in,
	input wire logic act_b_in,
	input wire logic [cmd_addr_pkg::ADDR_W-1:0] addr_in,
	input wire logic [1:0] bg_in,
	input wire logic [1:0] ba_in,
	input wire logic odt_in,
	input wire logic strobe_beat_in,
	input wire logic [DATA_W-1:0] wr_data_in,
	input wire logic dm_dbi_b_in,
	output logic cmd_valid_out,
	output logic [2:0] cmd_rcw_out,
	output logic act_out,
	output logic [15:0] row_addr_out,
	output logic [cmd_addr_pkg::COL_W-1:0] col_addr_out,
	output logic [cmd_addr_pkg::OPCODE_W-1:0] opcode_out,
	output logic [1:0] bg_out,
	output logic [1:0] ba_out,
	output logic [3:0] mr_sel_out,
	output logic auto_precharge_flag_out,
	output logic burst_chop_flag_out,
	output logic precharge_all_out,
	output logic [cmd_addr_pkg::BANKS-1:0] open_rows_out,
	output cmd_addr_pkg::pwr_state_e pwr_state_out,
	output logic clocks_run_out,
	output logic cmd_buf_en_out,
	output logic odt_buf_en_out,
	output logic sr_exit_out,
	output logic nominal_termination_out,
	output logic termination_strobe_out,
	output logic dm_en_out,
	output logic wr_dbi_en_out,
	output logic rd_dbi_en_out,
	output logic wr_beat_valid_out,
	output logic [DATA_W-1:0] wr_beat_data_out,
	output logic [cmd_addr_pkg::CR_W-1:0] config_register_one_out,
	output logic [cmd_addr_pkg::CR_W-1:0] config_register_five_out
);
	import cmd_addr_pkg::*;

	pwr_state_e pwr_ff;
	pwr_state_e nxt_pwr;
	logic cke_ff;
	logic [BANKS-1:0] open_ff;
	logic [CR_W-1:0] cr1_ff;
	logic [CR_W-1:0] cr5_ff;
	logic sel;
	logic is_act;
	logic [2:0] rcw;
	logic [3:0] bank_idx;
	logic odt_ff;
	logic awake;
	logic nonact;
	logic rw_cmd;
	logic pre_cmd;
	logic mrs_cmd;
	logic refresh_req;
	logic [3:0] cr_idx;
	logic beat_live;

	function automatic logic [3:0] bank_index(input logic [1:0] bg, input logic [1:0] ba);
		logic [1:0] g;
		g = bg;
		if (!BYTE_WIDE) begin
			g[1] = 1'b0;
		end
		bank_index = {g, ba};
	endfunction

	// read or write command on the row, column and write pins
	function automatic logic is_rw(input logic [2:0] c);
		is_rw = (c == CMD_WR) || (c == CMD_RD);
	endfunction

	// register index of a mode register set, second group input unused
	function automatic logic [3:0] cr_index(input logic [1:0] bg, input logic [1:0] ba);
		cr_index = {1'b0, bg[0], ba};
	endfunction

	// bank flag addressed by the sampled group and bank inputs
	function automatic logic bank_hit(input logic [3:0] idx, input int unsigned n);
		bank_hit = (idx == 4'(n));
	endfunction

	// command inputs live only while awake and chip select low
	assign awake = (pwr_ff == PWR_ACTIVE);
	assign sel = awake && cke_in && !cs_b_in;
	assign is_act = sel && !act_b_in;
	assign rcw = {addr_in[ROW_BIT_16], addr_in[ROW_BIT_15], addr_in[ROW_BIT_14]};
	assign bank_idx = bank_index(bg_in, ba_in);
	assign nonact = sel && act_b_in;
	assign rw_cmd = nonact && is_rw(rcw);
	assign pre_cmd = nonact && (rcw == CMD_PRE);
	assign mrs_cmd = nonact && (rcw == CMD_MRS);
	assign cr_idx = cr_index(bg_in, ba_in);
	assign refresh_req = !cs_b_in && act_b_in && (rcw == CMD_REF);

	// power state
	always_comb begin
		nxt_pwr = pwr_ff;
		unique case (pwr_ff)
			PWR_ACTIVE: begin
				if (!cke_in) begin
					if (open_ff != '0) begin
						nxt_pwr = PWR_ACT_PD;
					end else if (refresh_req) begin
						nxt_pwr = PWR_SELF_REF;
					end else begin
						nxt_pwr = PWR_PRE_PD;
					end
				end
			end
			PWR_PRE_PD: begin
				if (cke_in) begin
					nxt_pwr = PWR_ACTIVE;
				end
			end
			PWR_ACT_PD: begin
				if (cke_in) begin
					nxt_pwr = PWR_ACTIVE;
				end
			end
			PWR_SELF_REF: begin
				if (cke_in) begin
					nxt_pwr = PWR_ACTIVE;
				end
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			pwr_ff <= PWR_ACTIVE;
		end else begin
			pwr_ff <= nxt_pwr;
		end
	end

	// clock enable of the previous edge
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			cke_ff <= 1'b0;
		end else begin
			cke_ff <= cke_in;
		end
	end

	// self-refresh exit, seen on a clock edge
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			sr_exit_out <= 1'b0;
		end else begin
			sr_exit_out <= (pwr_ff == PWR_SELF_REF) && cke_in && !cke_ff;
		end
	end

	// clock and buffer gating
	assign pwr_state_out = pwr_ff;
	assign clocks_run_out = awake;
	assign cmd_buf_en_out = awake;
	assign odt_buf_en_out = (pwr_ff != PWR_SELF_REF);

	// command pulses
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			cmd_valid_out <= 1'b0;
			act_out <= 1'b0;
			cmd_rcw_out <= '1;
		end else begin
			cmd_valid_out <= sel;
			act_out <= is_act;
			cmd_rcw_out <= nonact ? rcw : '1;
		end
	end

	// row address, held until the next activate
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			row_addr_out <= '0;
		end else if (is_act) begin
			row_addr_out <= addr_in[ROW_W-1:0];
		end
	end

	// column, opcode and register select, held until the next non-activate
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			col_addr_out <= '0;
			opcode_out <= '0;
			mr_sel_out <= '0;
		end else if (nonact) begin
			col_addr_out <= addr_in[COL_W-1:0];
			opcode_out <= addr_in[OPCODE_W-1:0];
			mr_sel_out <= cr_idx;
		end
	end

	// target bank inputs, sampled on every clock edge whatever the command
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			bg_out <= '0;
			ba_out <= '0;
		end else begin
			bg_out <= bank_idx[3:2];
			ba_out <= ba_in;
		end
	end

	// access qualifiers, read and write alike, and the precharge-all flag of a precharge
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			auto_precharge_flag_out <= 1'b0;
			burst_chop_flag_out <= 1'b0;
			precharge_all_out <= 1'b0;
		end else begin
			auto_precharge_flag_out <= rw_cmd && addr_in[AP_BIT];
			burst_chop_flag_out <= rw_cmd && !addr_in[BC_BIT];
			precharge_all_out <= pre_cmd && addr_in[AP_BIT];
		end
	end

	// open row tracking, one flag per bank
	for (genvar i = 0; i < BANKS; i++) begin : g_bank
		always_ff @(posedge clock_in) begin
			if (!rst_b_in) begin
				open_ff[i] <= 1'b0;
			end else if (is_act && bank_hit(bank_idx, i)) begin
				open_ff[i] <= 1'b1;
			end else if (pre_cmd) begin
				if (addr_in[AP_BIT] || bank_hit(bank_idx, i)) begin
					open_ff[i] <= 1'b0;
				end
			end else if (rw_cmd && addr_in[AP_BIT]) begin
				if (bank_hit(bank_idx, i)) begin
					open_ff[i] <= 1'b0;
				end
			end
		end
	end
	assign open_rows_out = open_ff;

	// configuration registers
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			cr1_ff <= '0;
		end else if (mrs_cmd && cr_idx == CR1_IDX) begin
			cr1_ff <= CR_W'(addr_in);
		end
	end

	// fifth register
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			cr5_ff <= '0;
		end else if (mrs_cmd && cr_idx == CR5_IDX) begin
			cr5_ff <= CR_W'(addr_in);
		end
	end

	// stored registers and their fields
	assign config_register_one_out = cr1_ff;
	assign config_register_five_out = cr5_ff;
	assign dm_en_out = cr5_ff[CR5_DM_BIT];
	assign wr_dbi_en_out = cr5_ff[CR5_WDBI_BIT];
	assign rd_dbi_en_out = cr5_ff[CR5_RDBI_BIT];
	assign termination_strobe_out = BYTE_WIDE && cr1_ff[CR1_TSTROBE_BIT];

	// termination enable
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			odt_ff <= 1'b0;
		end else begin
			odt_ff <= odt_in && (pwr_ff != PWR_SELF_REF);
		end
	end
	assign nominal_termination_out = odt_ff && (cr1_ff[CR1_NOM_TERM_HI:CR1_NOM_TERM_LO] != '0);

	// beats count only while awake
	assign beat_live = strobe_beat_in && awake;

	// write beats, one beat per clock edge while awake and the strobe beat input is high, unless masked
	mask_inv_lane #(
		.DATA_W(DATA_W)
	) u_lane (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.beat_valid_in(beat_live),
		.beat_data_in(wr_data_in),
		.dm_dbi_b_in(dm_dbi_b_in),
		.mask_en_in(cr5_ff[CR5_DM_BIT]),
		.inv_en_in(cr5_ff[CR5_WDBI_BIT]),
		.beat_valid_out(wr_beat_valid_out),
		.beat_data_out(wr_beat_data_out)
	);
endmodule
`default_nettype wire

// ---- hw/cmd_addr_pkg.sv ----
// constants for the command and address pin decoder
package cmd_addr_pkg;
	localparam int ADDR_W = 17;
	localparam int ROW_BIT_14 = 14;
	localparam int ROW_BIT_15 = 15;
	localparam int ROW_BIT_16 = 16;
	localparam int AP_BIT = 10;
	localparam int BC_BIT = 12;
	localparam int COL_W = 10;
	localparam int OPCODE_W = 14;
	localparam int CR1_NOM_TERM_LO = 8;
	localparam int CR1_NOM_TERM_HI = 10;
	localparam int CR1_TSTROBE_BIT = 11;
	localparam int CR5_DM_BIT = 10;
	localparam int CR5_WDBI_BIT = 11;
	localparam int CR5_RDBI_BIT = 12;
	localparam int CR_W = 18;
	localparam int BANKS = 16;
	localparam int ROW_W = 16;
	localparam logic [3:0] CR1_IDX = 4'h1;
	localparam logic [3:0] CR5_IDX = 4'h5;
	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'b00,
		PWR_PRE_PD = 2'b01,
		PWR_SELF_REF = 2'b11,
		PWR_ACT_PD = 2'b10
	} pwr_state_e;
	localparam logic [2:0] CMD_MRS = 3'b000;
	localparam logic [2:0] CMD_REF = 3'b001;
	localparam logic [2:0] CMD_PRE = 3'b010;
	localparam logic [2:0] CMD_WR = 3'b100;
	localparam logic [2:0] CMD_RD = 3'b101;
endpackage

// ---- hw/mask_inv_lane.sv ----
// one data lane with mask and inversion handling
`timescale 1ns/1ns
`default_nettype none
module mask_inv_lane #(
	parameter int DATA_W = 8
) (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic beat_valid_in,
	input wire logic [DATA_W-1:0] beat_data_in,
	input wire logic dm_dbi_b_in,
	input wire logic mask_en_in,
	input wire logic inv_en_in,
	output logic beat_valid_out,
	output logic [DATA_W-1:0] beat_data_out
);
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			beat_valid_out <= 1'b0;
			beat_data_out <= '0;
		end else begin
			beat_valid_out <= beat_valid_in && !(mask_en_in && !dm_dbi_b_in);
			if (inv_en_in && !dm_dbi_b_in) begin
				beat_data_out <= ~beat_data_in;
			end else begin
				beat_data_out <= beat_data_in;
			end
		end
	end
endmodule
`default_nettype wire

// ---- testbench/cad_asserts.sv ----
// checker for the command decoder ports
`timescale 1ns/1ns
`default_nettype none
module cad_chk (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic cke_in,
	input wire logic cs_b_in,
	input wire logic act_b_in,
	input wire logic [cmd_addr_pkg::ADDR_W-1:0] addr_in,
	input wire logic cmd_valid_out,
	input wire logic act_out,
	input wire logic [2:0] cmd_rcw_out,
	input wire logic auto_precharge_flag_out,
	input wire logic burst_chop_flag_out,
	input wire cmd_addr_pkg::pwr_state_e pwr_state_out
);
	import cmd_addr_pkg::*;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	wire on = pwr_state_out == PWR_ACTIVE;
	wire tk = on && cke_in && !cs_b_in;
	sequence s_rw; tk && act_b_in && addr_in[16:15] == 2'b10; endsequence
	property p_cs; cs_b_in |=> !cmd_valid_out && !act_out; endproperty
	a_cs: assert property (p_cs) else $error("deselected command");
	property p_ck; !cke_in |=> !cmd_valid_out; endproperty
	a_ck: assert property (p_ck) else $error("asleep command");
	property p_ac; tk && !act_b_in |=> act_out; endproperty
	a_ac: assert property (p_ac) else $error("no activate");
	property p_rc; tk && act_b_in |=> cmd_rcw_out == $past(addr_in[16:14]); endproperty
	a_rc: assert property (p_rc) else $error("bad command");
	property p_ap; s_rw |=> auto_precharge_flag_out == $past(addr_in[10]); endproperty
	a_ap: assert property (p_ap) else $error("bad precharge flag");
	property p_bc; s_rw |=> burst_chop_flag_out != $past(addr_in[12]); endproperty
	a_bc: assert property (p_bc) else $error("bad chop flag");
	property p_pd; on && !cke_in |=> !on; endproperty
	a_pd: assert property (p_pd) else $error("no sleep");
	property p_sx; pwr_state_out == PWR_SELF_REF && cke_in |=> on; endproperty
	a_sx: assert property (p_sx) else $error("no wake");
endmodule
bind ddr4_cmd_addr_pin_decode cad_chk chk_u (.*);
`default_nettype wire

// ---- testbench/ctl_model.sv ----
// controller model driving command and write pins
`timescale 1ns/1ns
`default_nettype none
module ctl_model (
	input wire logic clock_in,
	output logic cke_out,
	output logic cs_b_out,
	output logic act_b_out,
	output logic [16:0] addr_out,
	output logic odt_out,
	output logic [1:0] bg_out,
	output logic [1:0] ba_out,
	output logic beat_out,
	output logic dm_out,
	output logic [7:0] data_out
);
	initial {cke_out, cs_b_out, act_b_out, addr_out, odt_out, bg_out, ba_out,
		beat_out, dm_out, data_out} = {3'b111, 32'h0};
	task automatic iss(input logic [2:0] c, input logic [16:0] a, input logic [4:0] b,
		input logic [9:0] w = 10'h100);
		@(posedge clock_in);
		#1;
		{cke_out, cs_b_out, act_b_out} = c;
		{addr_out, odt_out, bg_out, ba_out} = {a, b};
		{beat_out, dm_out, data_out} = w;
		@(posedge clock_in);
		#1;
		cs_b_out = 1'b1;
		beat_out = 1'b0;
		{addr_out, dm_out, data_out} = ~{a, w[8:0]};
	endtask
endmodule
`default_nettype wire

// ---- testbench/ddr4_cmd_addr_pin_decode_tb_top.sv ----
// bench for the command and address decoder
`timescale 1ns/1ns
`default_nettype none
module ddr4_cmd_addr_pin_decode_tb_top;
	import cmd_addr_pkg::*;
	logic clock_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic cke_in, cs_b_in, act_b_in, odt_in, strobe_beat_in, dm_dbi_b_in, cmd_valid_out, act_out;
	logic auto_precharge_flag_out, burst_chop_flag_out, precharge_all_out, clocks_run_out;
	logic cmd_buf_en_out, odt_buf_en_out, sr_exit_out, nominal_termination_out, dm_en_out;
	logic termination_strobe_out, wr_dbi_en_out, rd_dbi_en_out, wr_beat_valid_out;
	logic [16:0] addr_in, a;
	logic [1:0] bg_in, ba_in, bg_out, ba_out;
	logic [7:0] wr_data_in, wr_beat_data_out;
	logic [2:0] cmd_rcw_out;
	logic [15:0] row_addr_out, open_rows_out;
	logic [9:0] col_addr_out;
	logic [13:0] opcode_out;
	logic [3:0] mr_sel_out;
	logic [17:0] config_register_one_out, config_register_five_out;
	logic [4:0] b;
	pwr_state_e pwr_state_out;
	int n_errors = 0, check_count = 0, cyc = 0;
	always #20 clock_in = ~clock_in;
	ddr4_cmd_addr_pin_decode dut_u (.*);
	ctl_model ctl_u (.clock_in, .cke_out(cke_in), .cs_b_out(cs_b_in), .act_b_out(act_b_in),
		.addr_out(addr_in), .odt_out(odt_in), .bg_out(bg_in), .ba_out(ba_in),
		.beat_out(strobe_beat_in), .dm_out(dm_dbi_b_in), .data_out(wr_data_in));
	task automatic ck(input logic [31:0] g, e);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: %h vs %h", $time, g, e);
		end
	endtask
	task automatic close_out();
		$display("%0d checks, %0d errors", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	function automatic logic [11:0] rw(input logic [16:0] x);
		return {x[AP_BIT], ~x[BC_BIT], x[COL_W-1:0]};
	endfunction
	function automatic logic [8:0] bt(input logic [7:0] x, input logic i, m);
		return (!i && !m) ? 9'h0 : {1'b1, (i && !m) ? ~x : x};
	endfunction
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 1000) begin
			n_errors++;
			close_out();
		end
	end
	initial begin
		void'($urandom(32'hcc12d9e7));
		repeat (8) @(posedge clock_in);
		#1;
		rst_b_in = 1'b1;
		ck({cmd_rcw_out, pwr_state_out, open_rows_out}, {3'b111, PWR_ACTIVE, 16'h0});
		$display("reset done");
		for (int i = 0; i < 20; i++) begin
			a = 17'($urandom);
			b = 5'($urandom);
			ctl_u.iss(3'b100, a, b);
			ck({act_out, row_addr_out, open_rows_out[b[3:0]]}, {1'b1, a[15:0], 1'b1});
			a[16:15] = 2'b10;
			ctl_u.iss(3'b101, a, b);
			ck({cmd_rcw_out, auto_precharge_flag_out, burst_chop_flag_out, col_addr_out, bg_out,
				ba_out}, {a[16:14], rw(a), b[3:0]});
			ck(opcode_out, a[OPCODE_W-1:0]);
			a[16:14] = 3'b010;
			ctl_u.iss(3'b101, a, b);
			ck({precharge_all_out, open_rows_out[b[3:0]]}, {a[10], 1'b0});
		end
		$display("decode done");
		ctl_u.iss(3'b100, a, 5'h3);
		ctl_u.iss(3'b011, a, 5'h0);
		ck({pwr_state_out, clocks_run_out, cmd_buf_en_out}, {PWR_ACT_PD, 2'b00});
		ctl_u.iss(3'b111, a, 5'h0);
		ctl_u.iss(3'b101, 17'h08400, 5'h0);
		ctl_u.iss(3'b001, 17'h04000, 5'h0);
		ck({pwr_state_out, odt_buf_en_out}, {PWR_SELF_REF, 1'b0});
		ctl_u.iss(3'b111, a, 5'h0);
		ck({pwr_state_out, sr_exit_out}, {PWR_ACTIVE, 1'b1});
		ctl_u.iss(3'b011, a, 5'h0);
		ck({pwr_state_out, clocks_run_out, cmd_buf_en_out, odt_buf_en_out},
			{PWR_PRE_PD, 3'b001});
		ctl_u.iss(3'b111, a, 5'h0);
		ck({pwr_state_out, sr_exit_out}, {PWR_ACTIVE, 1'b0});
		$display("power done");
		ctl_u.iss(3'b101, 17'h00900, 5'h11);
		ck({mr_sel_out, config_register_one_out, nominal_termination_out,
			termination_strobe_out}, {4'h1, 18'h00900, 2'b11});
		ctl_u.iss(3'b101, 17'h0, 5'h11);
		ck({nominal_termination_out, termination_strobe_out}, 2'b00);
		for (int m = 0; m < 2; m++) begin
			ctl_u.iss(3'b101, m ? 17'h00800 : 17'h00400, 5'h05);
			ck({dm_en_out, wr_dbi_en_out, rd_dbi_en_out}, {~m[0], m[0], 1'b0});
			ck(config_register_five_out, m ? 18'h00800 : 18'h00400);
			for (int d = 0; d < 2; d++) begin
				a = 17'($urandom);
				ctl_u.iss(3'b110, a, 5'h0, {1'b1, d[0], a[7:0]});
				ck({wr_beat_valid_out, wr_beat_valid_out ? wr_beat_data_out : 8'h0},
					bt(a[7:0], m[0], d[0]));
			end
		end
		$display("config done");
		close_out();
	end
endmodule
`default_nettype wire
